// ---- src/tio_pkg.sv ----
// Constants and types shared by the timed I/O port unit
package tio_pkg;
  localparam int NUM_PORTS = 5;
  localparam int NUM_CB = 6;
  localparam int PIN_W = 32;
  localparam int SYNC_W = PIN_W + NUM_PORTS;
  localparam int PORT_W [NUM_PORTS] = '{1, 4, 8, 16, 32};
  localparam int CNT_W_DEF = 16;
  localparam logic [31:0] LINK_PINS_DEF = 32'hF800_0000;
  localparam int CB_SRC_PIN = 0;
  localparam int IRQ_W = 2 * NUM_PORTS;

  // Global register byte offsets
  localparam logic [11:0] IRQ_STAT = 12'h000;
  localparam logic [11:0] IRQ_MASK = 12'h004;
  localparam logic [11:0] LINK_EN = 12'h008;
  localparam logic [11:0] CB_BASE = 12'h010;
  // Port pages: page number is address bits [11:5]
  localparam logic [6:0] PORT_PAGE = 7'h02;
  localparam logic [4:0] P_CTRL = 5'h00;
  localparam logic [4:0] P_DATA = 5'h04;
  localparam logic [4:0] P_TIME = 5'h08;
  localparam logic [4:0] P_COND = 5'h0C;
  localparam logic [4:0] P_COUNT = 5'h10;
  localparam logic [4:0] P_STAMP = 5'h14;
  localparam logic [4:0] P_STAT = 5'h18;

  typedef enum logic [1:0] {
    COND_NONE = 2'b00,
    COND_EQ = 2'b01,
    COND_NE = 2'b10
  } cond_mode_t;

  typedef struct packed {
    logic [2:0] clk_sel;
    cond_mode_t cond;
    logic timed;
    logic strobe_out;
    logic strobe_in;
    logic open_col;
    logic dir_out;
    logic en;
  } port_ctrl_t;

  typedef struct packed {
    logic [15:0] div;
    logic ext_src;
  } clk_cfg_t;

  localparam port_ctrl_t PORT_CTRL_RST = '0;
  localparam clk_cfg_t CLK_CFG_RST = '0;
endpackage : tio_pkg

// ---- src/timed_io_port_clock_blocks.sv ----
// Timed I/O ports with clock blocks behind an AHB-Lite register slave
`timescale 1ns/1ps
module timed_io_port_clock_blocks #(
  parameter int CNT_W = tio_pkg::CNT_W_DEF,
  parameter logic [31:0] LINK_PINS = tio_pkg::LINK_PINS_DEF
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Pins
  input wire logic [31:0] pin_in,
  output logic [31:0] pin_out,
  output logic [31:0] pin_oe,
  // Strobes, one per port
  input wire logic [4:0] strobe_in,
  output logic [4:0] outgoing_strobe,
  // Interrupt
  output logic irq
);
  localparam int NP = tio_pkg::NUM_PORTS;
  localparam int NCB = tio_pkg::NUM_CB;

  if (CNT_W < 1 || CNT_W > 16)
  begin : g_bad_cnt
    $error("CNT_W must lie between 1 and 16");
  end

  // Bus slave
  logic acc;
  logic wr_q;
  logic [11:0] wa_q;
  logic [31:0] rdata_d;
  logic [31:0] rd_port [NP];
  logic [NP-1:0] rd_take;

  assign acc = hsel && htrans[1] && hready;
  assign hreadyout = clk_en;
  assign hresp = 1'b0;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wr_q <= 1'b0;
      wa_q <= '0;
      hrdata <= '0;
    end
    else if (clk_en)
    begin
      wr_q <= acc && hwrite;
      wa_q <= haddr[11:0];
      if (acc && !hwrite)
      begin
        hrdata <= rdata_d;
      end
    end
  end

  // Pin and strobe synchronisers: a level counts once stages 2 and 3 agree
  logic [tio_pkg::SYNC_W-1:0] s1_q, s2_q, s3_q, f_q, fp_q;
  logic [31:0] pin_f;
  logic [NP-1:0] strb_f;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      f_q <= '0;
      fp_q <= '0;
    end
    else if (clk_en)
    begin
      s1_q <= {strobe_in, pin_in};
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q <= (s2_q & ~(s2_q ^ s3_q)) | (f_q & (s2_q ^ s3_q));
      fp_q <= f_q;
    end
  end

  assign pin_f = f_q[31:0];
  assign strb_f = f_q[tio_pkg::SYNC_W-1:32];

  // Clock blocks
  logic [NCB-1:0] cb_tick;
  tio_pkg::clk_cfg_t cb_cfg [NCB];

  for (genvar c = 0; c < NCB; c++)
  begin : g_cb
    if (c == 0)
    begin : g_ref
      assign cb_cfg[c] = tio_pkg::CLK_CFG_RST;
      assign cb_tick[c] = 1'b1;
    end
    else
    begin : g_prog
      tio_pkg::clk_cfg_t cfg_q;
      logic [15:0] div_q;
      logic src_ev;

      // Rising edge of the filtered 1-bit port pin, or every reference cycle
      assign src_ev = cfg_q.ext_src ? (f_q[tio_pkg::CB_SRC_PIN] & ~fp_q[tio_pkg::CB_SRC_PIN]) : 1'b1;
      assign cb_tick[c] = src_ev && (div_q == cfg_q.div);
      assign cb_cfg[c] = cfg_q;

      always_ff @(posedge core_clk)
      begin
        if (rst)
        begin
          cfg_q <= tio_pkg::CLK_CFG_RST;
          div_q <= '0;
        end
        else if (clk_en)
        begin
          if (wr_q && wa_q == 12'(tio_pkg::CB_BASE + 4 * c))
          begin
            cfg_q <= hwdata[16:0];
            div_q <= '0;
          end
          else if (cb_tick[c])
          begin
            div_q <= '0;
          end
          else if (src_ev)
          begin
            div_q <= div_q + 16'h0001;
          end
        end
      end
    end
  end

  // Ports
  tio_pkg::port_ctrl_t pctl [NP];
  logic [31:0] drv_val [NP];
  logic [NP-1:0] rx_ev, tx_ev;

  for (genvar p = 0; p < NP; p++)
  begin : g_port
    localparam int W = tio_pkg::PORT_W[p];
    tio_pkg::port_ctrl_t ctrl_q;
    logic [W-1:0] tx_q, shift_q, rx_q, cond_q;
    logic [CNT_W-1:0] cnt_q, time_q, stamp_q;
    logic tx_full_q, rx_valid_q, strb_q;
    logic tick, time_ok, cond_ok, strb_ok, in_fire, out_fire, psel;

    assign psel = wr_q && wa_q[11:5] == 7'(tio_pkg::PORT_PAGE + p);
    assign rd_take[p] = acc && !hwrite && haddr[11:5] == 7'(tio_pkg::PORT_PAGE + p) && haddr[4:0] == tio_pkg::P_DATA;
    assign tick = (ctrl_q.clk_sel < 3'(NCB)) ? cb_tick[ctrl_q.clk_sel] : 1'b0;
    assign time_ok = !ctrl_q.timed || cnt_q == time_q;

    always_comb
    begin
      case (ctrl_q.cond)
        tio_pkg::COND_EQ: cond_ok = pin_f[W-1:0] == cond_q;
        tio_pkg::COND_NE: cond_ok = pin_f[W-1:0] != cond_q;
        default: cond_ok = 1'b1;
      endcase
    end

    assign strb_ok = !ctrl_q.strobe_in || strb_f[p];
    assign in_fire = ctrl_q.en && !ctrl_q.dir_out && tick && time_ok && cond_ok && strb_ok;
    assign out_fire = ctrl_q.en && ctrl_q.dir_out && tick && time_ok && tx_full_q;
    assign rx_ev[p] = in_fire;
    assign tx_ev[p] = out_fire;
    assign pctl[p] = ctrl_q;
    assign drv_val[p] = 32'(shift_q);
    assign outgoing_strobe[p] = strb_q;

    // Control, compare and condition registers
    always_ff @(posedge core_clk)
    begin
      if (rst)
      begin
        ctrl_q <= tio_pkg::PORT_CTRL_RST;
        time_q <= '0;
        cond_q <= '0;
      end
      else if (clk_en)
      begin
        if (psel && wa_q[4:0] == tio_pkg::P_CTRL)
        begin
          ctrl_q <= hwdata[10:0];
        end
        else if (psel && wa_q[4:0] == tio_pkg::P_TIME)
        begin
          time_q <= hwdata[CNT_W-1:0];
          ctrl_q.timed <= 1'b1;
        end
        else if (in_fire || out_fire)
        begin
          ctrl_q.timed <= 1'b0;
        end
        if (psel && wa_q[4:0] == tio_pkg::P_COND)
        begin
          cond_q <= hwdata[W-1:0];
        end
      end
    end

    // Counter and timestamp
    always_ff @(posedge core_clk)
    begin
      if (rst)
      begin
        cnt_q <= '0;
        stamp_q <= '0;
      end
      else if (clk_en)
      begin
        if (tick)
        begin
          cnt_q <= cnt_q + CNT_W'(1);
        end
        if (in_fire || out_fire)
        begin
          stamp_q <= cnt_q;
        end
      end
    end

    // Output path: transfer register to shift register
    always_ff @(posedge core_clk)
    begin
      if (rst)
      begin
        tx_q <= '0;
        tx_full_q <= 1'b0;
        shift_q <= '0;
        strb_q <= 1'b0;
      end
      else if (clk_en)
      begin
        if (out_fire)
        begin
          shift_q <= tx_q;
        end
        if (psel && wa_q[4:0] == tio_pkg::P_DATA)
        begin
          tx_q <= hwdata[W-1:0];
          tx_full_q <= 1'b1;
        end
        else if (out_fire)
        begin
          tx_full_q <= 1'b0;
        end
        if (tick)
        begin
          strb_q <= out_fire && ctrl_q.strobe_out;
        end
      end
    end

    // Input path: sampled pins into the transfer register
    always_ff @(posedge core_clk)
    begin
      if (rst)
      begin
        rx_q <= '0;
        rx_valid_q <= 1'b0;
      end
      else if (clk_en)
      begin
        if (in_fire)
        begin
          rx_q <= pin_f[W-1:0];
          rx_valid_q <= 1'b1;
        end
        else if (rd_take[p])
        begin
          rx_valid_q <= 1'b0;
        end
      end
    end

    always_comb
    begin
      case (haddr[4:0])
        tio_pkg::P_CTRL: rd_port[p] = 32'(ctrl_q);
        tio_pkg::P_DATA: rd_port[p] = 32'(rx_q);
        tio_pkg::P_TIME: rd_port[p] = 32'(time_q);
        tio_pkg::P_COND: rd_port[p] = 32'(cond_q);
        tio_pkg::P_COUNT: rd_port[p] = 32'(cnt_q);
        tio_pkg::P_STAMP: rd_port[p] = 32'(stamp_q);
        tio_pkg::P_STAT: rd_port[p] = {30'h0, tx_full_q, rx_valid_q};
        default: rd_port[p] = '0;
      endcase
    end
  end

  // Interrupt status, mask and link enable
  logic [tio_pkg::IRQ_W-1:0] stat_q, mask_q;
  logic link_en_q;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      stat_q <= '0;
      mask_q <= '0;
      link_en_q <= 1'b0;
      irq <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wr_q && wa_q == tio_pkg::IRQ_STAT)
      begin
        stat_q <= (stat_q & ~hwdata[tio_pkg::IRQ_W-1:0]) | {tx_ev, rx_ev};
      end
      else
      begin
        stat_q <= stat_q | {tx_ev, rx_ev};
      end
      if (wr_q && wa_q == tio_pkg::IRQ_MASK)
      begin
        mask_q <= hwdata[tio_pkg::IRQ_W-1:0];
      end
      if (wr_q && wa_q == tio_pkg::LINK_EN)
      begin
        link_en_q <= hwdata[0];
      end
      irq <= |(stat_q & mask_q);
    end
  end

  // Register read decode
  always_comb
  begin
    rdata_d = '0;
    if (haddr[11:0] == tio_pkg::IRQ_STAT)
    begin
      rdata_d = 32'(stat_q);
    end
    else if (haddr[11:0] == tio_pkg::IRQ_MASK)
    begin
      rdata_d = 32'(mask_q);
    end
    else if (haddr[11:0] == tio_pkg::LINK_EN)
    begin
      rdata_d = {31'h0, link_en_q};
    end
    for (int c = 1; c < NCB; c++)
    begin
      if (haddr[11:0] == 12'(tio_pkg::CB_BASE + 4 * c))
      begin
        rdata_d = 32'(cb_cfg[c]);
      end
    end
    for (int p = 0; p < NP; p++)
    begin
      if (haddr[11:5] == 7'(tio_pkg::PORT_PAGE + p))
      begin
        rdata_d = rd_port[p];
      end
    end
  end

  // Pin ownership and drive
  logic [31:0] pin_d, oe_d;

  always_comb
  begin
    logic taken;
    taken = 1'b0;
    pin_d = '0;
    oe_d = '0;
    for (int b = 0; b < tio_pkg::PIN_W; b++)
    begin
      taken = 1'b0;
      for (int p = 0; p < NP; p++)
      begin
        if (!taken && pctl[p].en && b < tio_pkg::PORT_W[p])
        begin
          taken = 1'b1;
          if (pctl[p].dir_out)
          begin
            pin_d[b] = pctl[p].open_col ? 1'b0 : drv_val[p][b];
            oe_d[b] = pctl[p].open_col ? !drv_val[p][b] : 1'b1;
          end
        end
      end
      if (link_en_q && LINK_PINS[b])
      begin
        pin_d[b] = 1'b0;
        oe_d[b] = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pin_out <= '0;
      pin_oe <= '0;
    end
    else if (clk_en)
    begin
      pin_out <= pin_d;
      pin_oe <= oe_d;
    end
  end
endmodule : timed_io_port_clock_blocks

// ---- test/tio_assertions.sv ----
// Concurrent checks on the timed I/O port unit
`timescale 1ns/1ps
module tio_assertions #(
  parameter logic [31:0] LINK_PINS = tio_pkg::LINK_PINS_DEF
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Pins and events
  input wire logic [31:0] pin_oe,
  input wire logic [31:0] pin_out,
  input wire logic [4:0] outgoing_strobe,
  input wire logic irq
);
  logic take, wph_q, link_q, wrote_q;
  logic [11:0] adr_q;
  assign take = hsel && htrans[1] && hready;
  // Write data phase tracking
  always_ff @(posedge core_clk)
  begin
    if (hready)
      wph_q <= take && hwrite && !rst;
    if (take)
      adr_q <= haddr[11:0];
  end
  // Shadow of the link enable bit
  always_ff @(posedge core_clk)
  begin
    if (rst)
      link_q <= 1'b0;
    else if (wph_q && hready && adr_q == tio_pkg::LINK_EN)
      link_q <= hwdata[0];
  end
  always_ff @(posedge core_clk)
  begin
    if (rst)
      wrote_q <= 1'b0;
    else if (take && hwrite)
      wrote_q <= 1'b1;
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  chk_no_wait: assert property (hreadyout == clk_en)
    else $error("wait state");
  chk_resp_okay: assert property (!hresp)
    else $error("bad response");
  chk_rst_quiet: assert property ($past(rst) |-> pin_oe == 32'h0 && pin_out == 32'h0
    && outgoing_strobe == 5'h0 && !irq && hrdata == 32'h0)
    else $error("reset state wrong");
  chk_freeze_pins: assert property (!clk_en |=> $stable(pin_out) && $stable(pin_oe) && $stable(irq))
    else $error("moved while frozen");
  chk_rdata_hold: assert property ($changed(hrdata) |-> ($past(take) && !$past(hwrite)) || $past(rst))
    else $error("read data moved");
  chk_link_off: assert property (link_q && $past(link_q, 3) |-> (pin_oe & LINK_PINS) == 32'h0)
    else $error("link pins driven");
  chk_oe_quiet: assert property (!wrote_q |-> pin_oe == 32'h0)
    else $error("drive before setup");
  chk_irq_cause: assert property ($fell(irq) |-> $past(wph_q) || $past(wph_q, 2) || $past(rst))
    else $error("irq fell alone");
  cover property (irq);
  cover property (link_q && $past(link_q, 3));
  cover property (outgoing_strobe != 5'h0);
endmodule : tio_assertions

bind timed_io_port_clock_blocks tio_assertions #(.LINK_PINS(LINK_PINS)) tio_assertions_inst (.*);

// ---- test/pin_partner.sv ----
// Model of the hardware wired to the port pins
`timescale 1ns/1ps
module pin_partner (
  // Device side
  input wire logic [31:0] pin_out,
  input wire logic [31:0] pin_oe,
  output logic [31:0] pin_in,
  output logic [4:0] strobe_in,
  // Bench control
  input wire logic [31:0] ext_val,
  input wire logic ext_en,
  input wire logic stb
);
  // Pulled down unless someone drives
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_val & {32{ext_en}});
  assign strobe_in = {5{ext_en & stb}};
endmodule : pin_partner

// ---- test/tb_top.sv ----
// Self-checking bench for the timed I/O port unit
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    n_tests++; \
    if ((a) !== (b)) \
    begin \
      n_mismatch++; \
      $display("ERROR %0t got %h want %h", $time, (a), (b)); \
    end \
  end
module tb_top;
  logic core_clk = 0;
  logic rst = 1;
  logic clk_en = 1;
  logic hsel = 0;
  logic hwrite = 0;
  logic ext_en = 0;
  logic stb = 0;
  logic seen_q = 0;
  logic hreadyout, hresp, irq;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [4:0] strobe_in, outgoing_strobe;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] ext_val = 32'h0;
  logic [31:0] hrdata, pin_in, pin_out, pin_oe, rd, c0;
  int n_mismatch = 0;
  int n_tests = 0;

  timed_io_port_clock_blocks timed_io_port_clock_blocks_inst (.hready(hreadyout), .*);
  pin_partner pin_partner_inst (.*);

  initial
    forever #12.5 core_clk = ~core_clk;

  always @(posedge core_clk)
    seen_q <= seen_q | (|outgoing_strobe);

  function automatic logic [11:0] pa(input logic [2:0] p, input logic [4:0] r);
    return {tio_pkg::PORT_PAGE + {4'h0, p}, r};
  endfunction : pa

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d = 32'h0);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0_0000, a};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic t_reset();
    for (logic [2:0] p = 3'h0; p < 3'h5; p++)
    begin
      ahb(1'b0, pa(p, 5'h00));
      `CHK(rd, 32'h0000_0000)
    end
    `CHK(pin_oe, 32'h0000_0000)
    $display("reset test done");
  endtask : t_reset

  task automatic t_out();
    ahb(1'b1, pa(3'h0, 5'h00), 32'h0000_0013);
    ahb(1'b1, pa(3'h0, 5'h04), 32'h0000_0001);
    cyc(3);
    `CHK({pin_oe[0], pin_out[0], seen_q, irq}, 4'hE)
    ahb(1'b0, 12'h000);
    `CHK(rd[5], 1'b1)
    ahb(1'b1, 12'h004, 32'h0000_0020);
    cyc(3);
    `CHK(irq, 1'b1)
    ahb(1'b1, 12'h000, 32'h0000_0020);
    cyc(3);
    `CHK(irq, 1'b0)
    ahb(1'b1, 12'hFFC, 32'hFFFF_FFFF);
    ahb(1'b0, 12'hFFC);
    `CHK(rd, 32'h0000_0000)
    clk_en <= 1'b0;
    cyc(3);
    clk_en <= 1'b1;
    ahb(1'b1, pa(3'h0, 5'h00), 32'h0000_0017);
    ahb(1'b1, pa(3'h0, 5'h04), 32'h0000_0001);
    cyc(3);
    `CHK(pin_oe[0], 1'b0)
    ahb(1'b1, pa(3'h0, 5'h04), 32'h0000_0000);
    cyc(3);
    `CHK({pin_oe[0], pin_out[0]}, 2'b10)
    $display("output test done");
  endtask : t_out

  task automatic t_share();
    ahb(1'b1, pa(3'h0, 5'h00), 32'h0);
    for (logic [2:0] p = 3'h1; p < 3'h5; p++)
    begin
      ahb(1'b1, pa(p, 5'h00), 32'h0000_0003);
      ahb(1'b1, pa(p, 5'h04), p == 3'h1 ? 32'h0 : 32'hFFFF_FFFF);
    end
    cyc(3);
    `CHK(pin_out, 32'hFFFF_FFF0)
    `CHK(pin_oe, 32'hFFFF_FFFF)
    ahb(1'b1, 12'h008, 32'h0000_0001);
    cyc(3);
    `CHK(pin_oe, ~tio_pkg::LINK_PINS_DEF)
    ahb(1'b1, 12'h008, 32'h0);
    cyc(3);
    `CHK(pin_oe, 32'hFFFF_FFFF)
    for (logic [2:0] p = 3'h1; p < 3'h5; p++)
      ahb(1'b1, pa(p, 5'h00), 32'h0);
    $display("sharing test done");
  endtask : t_share

  task automatic t_timed();
    ahb(1'b1, pa(3'h0, 5'h00), 32'h0000_0003);
    ahb(1'b0, pa(3'h0, 5'h10));
    c0 = rd;
    ahb(1'b0, pa(3'h0, 5'h10));
    `CHK(rd[15:0], c0[15:0] + 16'h0002)
    c0 = c0 + 32'h0000_0028;
    ahb(1'b1, pa(3'h0, 5'h08), c0);
    ahb(1'b1, pa(3'h0, 5'h04), 32'h0000_0001);
    cyc(10);
    `CHK(pin_out[0], 1'b0)
    cyc(40);
    `CHK(pin_out[0], 1'b1)
    ahb(1'b0, pa(3'h0, 5'h14));
    `CHK(rd[15:0], c0[15:0])
    ahb(1'b1, pa(3'h0, 5'h00), 32'h0);
    $display("timed test done");
  endtask : t_timed

  task automatic t_input();
    ahb(1'b1, pa(3'h2, 5'h00), 32'h0000_0009);
    ext_val <= 32'h0000_00A5;
    ext_en <= 1'b1;
    cyc(8);
    ahb(1'b0, pa(3'h2, 5'h18));
    `CHK(rd[0], 1'b0)
    stb <= 1'b1;
    cyc(8);
    ahb(1'b0, pa(3'h2, 5'h04));
    `CHK(rd[7:0], 8'hA5)
    stb <= 1'b0;
    ahb(1'b1, pa(3'h2, 5'h0C), 32'h0000_005A);
    ahb(1'b1, pa(3'h2, 5'h00), 32'h0000_0041);
    `CHK(pin_oe, 32'h0000_0000)
    ahb(1'b0, pa(3'h2, 5'h04));
    cyc(8);
    ahb(1'b0, pa(3'h2, 5'h18));
    `CHK(rd[0], 1'b0)
    ext_val <= 32'h0000_005A;
    cyc(8);
    ahb(1'b0, pa(3'h2, 5'h04));
    `CHK(rd[7:0], 8'h5A)
    ahb(1'b1, pa(3'h2, 5'h00), 32'h0000_0081);
    ahb(1'b0, pa(3'h2, 5'h04));
    cyc(8);
    ahb(1'b0, pa(3'h2, 5'h18));
    `CHK(rd[0], 1'b0)
    ext_val <= 32'h0000_0000;
    cyc(8);
    ahb(1'b0, pa(3'h2, 5'h18));
    `CHK(rd[0], 1'b1)
    ahb(1'b1, pa(3'h2, 5'h00), 32'h0);
    $display("input test done");
  endtask : t_input

  task automatic t_clock();
    ahb(1'b1, 12'h010, 32'hFFFF_FFFF);
    ahb(1'b0, 12'h010);
    `CHK(rd, 32'h0000_0000)
    ahb(1'b1, 12'h014, 32'h0000_0003);
    ahb(1'b1, pa(3'h3, 5'h00), 32'h0000_0101);
    ext_val <= 32'h0;
    cyc(8);
    ahb(1'b0, pa(3'h3, 5'h10));
    c0 = rd;
    repeat (4)
    begin
      ext_val[0] <= 1'b1;
      cyc(8);
      ext_val[0] <= 1'b0;
      cyc(8);
    end
    ahb(1'b0, pa(3'h3, 5'h10));
    `CHK(rd[15:0], c0[15:0] + 16'h0002)
    ext_en <= 1'b0;
    $display("clock block test done");
  endtask : t_clock

  task automatic final_report();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report

  initial
  begin
    repeat (5000) @(posedge core_clk);
    n_mismatch++;
    final_report();
  end

  initial
  begin
    cyc(10);
    rst <= 1'b0;
    t_reset();
    t_out();
    t_share();
    t_timed();
    t_input();
    t_clock();
    final_report();
  end
endmodule : tb_top
